// ===== short_packet_command_decoder.sv
// Functional notes
// (R1) Type 0x12 enters low-color mode
// (R2) Type 0x22 switches display off
// (R3) Receiver stays active while display is off
// (R4) Type 0x32 switches display back on
// (R5) Generic writes 0x03/0x13/0x23 passed on uninterpreted
// (R6) Short packets are exactly four bytes
// (R7) Data type bits [5:4] give parameter count
// (R8) Host zeroes second byte for one parameter
// (R9) Generic reads 0x04/0x14/0x24 request returned data
// (R10) Responses never exceed host maximum return size
// (R11) Host splits large reads over several transmissions
// (R12) Host performs turnaround after a read request
// (R13) Errored read request answered with error report
// (R14) Corrected read: data then error report
// (R15) Clean read: data with correct check byte
// (R16) Read request is last packet of transmission
// (R17) Peripheral sends response then returns the bus
// (R18) Byte after identifier is command-set opcode
// (R19) Host zeroes second byte for parameterless command
// (R20) Two-parameter command-set commands never sent short
// (R21) Type 0x02 leaves low-color mode
// (R22) Check byte verified; unknown types ignored
`timescale 1ns/10ps
`include "spcd_defs.svh"
module short_packet_command_decoder (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  spcd_if.dev              lnk,
  output logic             o_low_color,
  output logic             o_display_on,
  output logic             o_gen_wr_valid,
  output logic             o_dcs_wr_valid,
  output logic             o_rd_req,
  output logic             o_rd_dcs,
  output logic [1:0]       o_param_count,
  output logic [7:0]       o_param0,
  output logic [7:0]       o_param1,
  output logic [1:0]       o_err_flags,
  input  wire logic        i_rd_valid,
  input  wire logic [15:0] i_rd_data
);

  logic [1:0]  cnt_ff,     nxt_cnt;
  logic [23:0] rx_ff,      nxt_rx;
  logic        low_ff,     nxt_low;
  logic        on_ff,      nxt_on;
  logic        gwr_ff,     nxt_gwr;
  logic        dwr_ff,     nxt_dwr;
  logic        rdreq_ff,   nxt_rdreq;
  logic        rddcs_ff,   nxt_rddcs;
  logic [1:0]  pcnt_ff,    nxt_pcnt;
  logic [7:0]  d0_ff,      nxt_d0;
  logic [7:0]  d1_ff,      nxt_d1;
  logic        pend_ff,    nxt_pend;
  logic        have_ff,    nxt_have;
  logic [15:0] rdat_ff,    nxt_rdat;
  logic [1:0]  err_ff,     nxt_err;
  logic [23:0] fix;
  logic [5:0]  syn;
  logic        bad;
  logic        corr;

  spcd_pkg::dev_state_type st_ff, nxt_st;
  logic [63:0] tbuf_ff,    nxt_tbuf;
  logic [3:0]  tlen_ff,    nxt_tlen;
  logic        dv_ff,      nxt_dv;
  logic [7:0]  dd_ff,      nxt_dd;
  logic        done_ff,    nxt_done;
  logic        start;
  logic [31:0] rsp_pkt;
  logic [31:0] err_pkt;

  // Receive and decode
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_rx    = rx_ff;
    nxt_low   = low_ff;
    nxt_on    = on_ff;
    nxt_gwr   = 1'b0;
    nxt_dwr   = 1'b0;
    nxt_rdreq = 1'b0;
    nxt_rddcs = rddcs_ff;
    nxt_pcnt  = pcnt_ff;
    nxt_d0    = d0_ff;
    nxt_d1    = d1_ff;
    nxt_pend  = pend_ff;
    nxt_have  = have_ff;
    nxt_rdat  = rdat_ff;
    nxt_err   = err_ff;
    fix       = rx_ff;
    syn       = lnk.h2d_data[5:0] ^ spcd_pkg::ecc_calc(rx_ff);
    bad       = 1'b0;
    corr      = 1'b0;
    // Clears come first so a flag set in the same cycle survives
    if (start) begin
      nxt_pend = 1'b0;
      nxt_have = 1'b0;
      nxt_err  = 2'b00;
    end
    if (pend_ff && !have_ff && i_rd_valid) begin
      nxt_have = 1'b1;
      nxt_rdat = i_rd_data;
    end
    // Display state never gates this path, so a wake-up is always heard
    if (lnk.h2d_valid) begin // R3
      nxt_rx  = {lnk.h2d_data, rx_ff[23:8]};
      nxt_cnt = lnk.h2d_last ? 2'b00 : cnt_ff + 2'b01;
      if (cnt_ff == 2'(`PKT_BYTES - 1)) begin // R6
        if (syn != 6'h00) begin // R22
          bad = 1'b1;
          for (int i = 0; i < 24; i++) begin
            if (spcd_pkg::ecc_col(i) == syn) begin
              fix[i] = ~rx_ff[i];
              bad    = 1'b0;
              corr   = 1'b1;
            end
          end
          if ($countones(syn) == 1) begin
            bad  = 1'b0;
            corr = 1'b1;
          end
        end
        if (bad) begin
          nxt_err[1] = 1'b1; // R13
          nxt_pend   = 1'b0;
        end else begin
          if (corr) nxt_err[0] = 1'b1; // R14
          nxt_pcnt = fix[`FIELD_CNT_LO+1:`FIELD_CNT_LO]; // R7
          nxt_d0   = fix[15:8]; // R18
          nxt_d1   = fix[23:16];
          unique case (fix[5:0])
            `DT_COLOR_ON:  nxt_low = 1'b1; // R1
            `DT_COLOR_OFF: nxt_low = 1'b0; // R21
            `DT_SHUTDOWN:  nxt_on  = 1'b0; // R2
            `DT_TURN_ON:   nxt_on  = 1'b1; // R4
            `DT_GEN_WR0, `DT_GEN_WR1, `DT_GEN_WR2: nxt_gwr = 1'b1; // R5
            `DT_DCS_WR0, `DT_DCS_WR1: nxt_dwr = 1'b1; // R18
            `DT_GEN_RD0, `DT_GEN_RD1, `DT_GEN_RD2, `DT_DCS_RD: begin // R9
              nxt_rdreq = 1'b1;
              nxt_rddcs = (fix[5:0] == `DT_DCS_RD);
              nxt_pend  = 1'b1;
              nxt_have  = 1'b0;
            end
            default: ; // R22
          endcase
        end
      end else if (lnk.h2d_last) begin
        nxt_err[1] = 1'b1; // R6
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cnt_ff   <= 2'b00;
      rx_ff    <= 24'h000000;
      low_ff   <= 1'b0;
      on_ff    <= 1'b1;
      gwr_ff   <= 1'b0;
      dwr_ff   <= 1'b0;
      rdreq_ff <= 1'b0;
      rddcs_ff <= 1'b0;
      pcnt_ff  <= 2'b00;
      d0_ff    <= 8'h00;
      d1_ff    <= 8'h00;
      pend_ff  <= 1'b0;
      have_ff  <= 1'b0;
      rdat_ff  <= 16'h0000;
      err_ff   <= 2'b00;
    end else begin
      cnt_ff   <= nxt_cnt;
      rx_ff    <= nxt_rx;
      low_ff   <= nxt_low;
      on_ff    <= nxt_on;
      gwr_ff   <= nxt_gwr;
      dwr_ff   <= nxt_dwr;
      rdreq_ff <= nxt_rdreq;
      rddcs_ff <= nxt_rddcs;
      pcnt_ff  <= nxt_pcnt;
      d0_ff    <= nxt_d0;
      d1_ff    <= nxt_d1;
      pend_ff  <= nxt_pend;
      have_ff  <= nxt_have;
      rdat_ff  <= nxt_rdat;
      err_ff   <= nxt_err;
    end
  end

  // Short response only: two bytes fit any maximum return size
  assign rsp_pkt = spcd_pkg::pkt_build({2'b00, `DT_RD_RESP}, rdat_ff); // R10 R15
  assign err_pkt = spcd_pkg::pkt_build({2'b00, `DT_ERR_RPT},
                                       16'({14'h0000, err_ff} << `ERR_POS));

  // Transmit after turnaround
  always_comb begin
    nxt_st   = st_ff;
    nxt_tbuf = tbuf_ff;
    nxt_tlen = tlen_ff;
    nxt_dv   = 1'b0;
    nxt_dd   = dd_ff;
    nxt_done = 1'b0;
    start    = 1'b0;
    unique case (st_ff)
      spcd_pkg::DEV_IDLE: begin
        if (lnk.bus_turnaround) begin
          if (pend_ff && !have_ff) nxt_st = spcd_pkg::DEV_WAIT;
          else start = 1'b1;
        end
      end
      spcd_pkg::DEV_WAIT: if (have_ff) start = 1'b1;
      spcd_pkg::DEV_SEND: begin
        nxt_dv   = 1'b1;
        nxt_dd   = tbuf_ff[7:0];
        nxt_tbuf = {8'h00, tbuf_ff[63:8]};
        nxt_tlen = tlen_ff - 4'h1;
        if (tlen_ff == 4'h1) nxt_st = spcd_pkg::DEV_DONE;
      end
      spcd_pkg::DEV_DONE: begin
        nxt_done = 1'b1; // R17
        nxt_st   = spcd_pkg::DEV_IDLE;
      end
    endcase
    if (start) begin
      if (pend_ff && err_ff != 2'b00) begin
        nxt_tbuf = {err_pkt, rsp_pkt}; // R14
        nxt_tlen = 4'h8;
      end else if (pend_ff) begin
        nxt_tbuf = {32'h00000000, rsp_pkt}; // R15
        nxt_tlen = 4'h4;
      end else if (err_ff != 2'b00) begin
        nxt_tbuf = {32'h00000000, err_pkt}; // R13
        nxt_tlen = 4'h4;
      end else begin
        nxt_tlen = 4'h0;
      end
      nxt_st = (nxt_tlen != 4'h0) ? spcd_pkg::DEV_SEND : spcd_pkg::DEV_DONE; // R17
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      st_ff   <= spcd_pkg::DEV_IDLE;
      tbuf_ff <= 64'h0000000000000000;
      tlen_ff <= 4'h0;
      dv_ff   <= 1'b0;
      dd_ff   <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      tbuf_ff <= nxt_tbuf;
      tlen_ff <= nxt_tlen;
      dv_ff   <= nxt_dv;
      dd_ff   <= nxt_dd;
      done_ff <= nxt_done;
    end
  end

  assign lnk.d2h_valid  = dv_ff;
  assign lnk.d2h_data   = dd_ff;
  assign lnk.d2h_done   = done_ff;
  assign o_low_color    = low_ff;
  assign o_display_on   = on_ff;
  assign o_gen_wr_valid = gwr_ff;
  assign o_dcs_wr_valid = dwr_ff;
  assign o_rd_req       = rdreq_ff;
  assign o_rd_dcs       = rddcs_ff;
  assign o_param_count  = pcnt_ff;
  assign o_param0       = d0_ff;
  assign o_param1       = d1_ff;
  assign o_err_flags    = err_ff;

endmodule : short_packet_command_decoder

// ===== spcd_defs.svh
`ifndef SPCD_DEFS_SVH
`define SPCD_DEFS_SVH
// Data types of received short packets
`define DT_COLOR_OFF 6'h02
`define DT_COLOR_ON  6'h12
`define DT_SHUTDOWN  6'h22
`define DT_TURN_ON   6'h32
`define DT_GEN_WR0   6'h03
`define DT_GEN_WR1   6'h13
`define DT_GEN_WR2   6'h23
`define DT_GEN_RD0   6'h04
`define DT_GEN_RD1   6'h14
`define DT_GEN_RD2   6'h24
`define DT_DCS_WR0   6'h05
`define DT_DCS_WR1   6'h15
`define DT_DCS_RD    6'h06
// Data types of returned packets
`define DT_RD_RESP   6'h1A
`define DT_ERR_RPT   6'h02
// Packet layout
`define PKT_BYTES    4
`define PARAM_ZERO   8'h00
`define FIELD_CNT_LO 4
`define ERR_POS      8
`endif

// ===== spcd_pkg.sv
package spcd_pkg;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_WAIT = 2'b01,
    DEV_SEND = 2'b11,
    DEV_DONE = 2'b10
  } dev_state_type;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_SEND = 2'b01,
    HOST_TURN = 2'b11,
    HOST_WAIT = 2'b10
  } host_state_type;

  // Column of header bit idx in the check matrix: distinct codes of weight two or more,
  // so a one-hot syndrome always points at a check bit, never at a header bit
  function automatic logic [5:0] ecc_col(input int idx);
    logic [5:0] v;
    int         n;
    ecc_col = 6'h00;
    n = 0;
    for (int c = 3; c < 64; c++) begin
      v = 6'(c);
      if ($countones(v) >= 2) begin
        if (n == idx) ecc_col = v;
        n++;
      end
    end
  endfunction : ecc_col

  function automatic logic [5:0] ecc_calc(input logic [23:0] hdr);
    ecc_calc = 6'h00;
    for (int i = 0; i < 24; i++) begin
      if (hdr[i]) ecc_calc = ecc_calc ^ ecc_col(i);
    end
  endfunction : ecc_calc

  // Byte 0 (identifier) sits in the low bits and goes out first
  function automatic logic [31:0] pkt_build(input logic [7:0] di, input logic [15:0] pay);
    pkt_build = {2'b00, ecc_calc({pay, di}), pay, di};
  endfunction : pkt_build

endpackage : spcd_pkg

// ===== spcd_if.sv
`timescale 1ns/10ps
interface spcd_if;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  logic       h2d_last;
  logic       bus_turnaround;
  logic       d2h_valid;
  logic [7:0] d2h_data;
  logic       d2h_done;

  modport host (
    output h2d_valid, h2d_data, h2d_last, bus_turnaround,
    input  d2h_valid, d2h_data, d2h_done
  );
  modport dev (
    input  h2d_valid, h2d_data, h2d_last, bus_turnaround,
    output d2h_valid, d2h_data, d2h_done
  );
endinterface : spcd_if

// ===== short_packet_command_host.sv
`timescale 1ns/10ps
`include "spcd_defs.svh"
module short_packet_command_host (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  spcd_if.host             lnk,
  input  wire logic        i_cmd_valid,
  input  wire logic [5:0]  i_cmd_dt,
  input  wire logic [7:0]  i_cmd_d0,
  input  wire logic [7:0]  i_cmd_d1,
  input  wire logic        i_cmd_last,
  output logic             o_cmd_ready,
  output logic             o_cmd_reject,
  output logic             o_rsp_valid,
  output logic             o_rsp_data_ok,
  output logic [15:0]      o_rsp_data,
  output logic             o_rsp_err,
  output logic [15:0]      o_rsp_err_data
);

  spcd_pkg::host_state_type st_ff, nxt_st;
  logic [31:0] tbuf_ff,  nxt_tbuf;
  logic [1:0]  cnt_ff,   nxt_cnt;
  logic        last_ff,  nxt_last;
  logic        isrd_ff,  nxt_isrd;
  logic        hv_ff,    nxt_hv;
  logic [7:0]  hd_ff,    nxt_hd;
  logic        hl_ff,    nxt_hl;
  logic        bta_ff,   nxt_bta;
  logic        rdy_ff,   nxt_rdy;
  logic        rej_ff,   nxt_rej;
  logic [23:0] rbuf_ff,  nxt_rbuf;
  logic [1:0]  rcnt_ff,  nxt_rcnt;
  logic        rv_ff,    nxt_rv;
  logic        rok_ff,   nxt_rok;
  logic [15:0] rd_ff,    nxt_rd;
  logic        re_ff,    nxt_re;
  logic [15:0] red_ff,   nxt_red;
  logic        is_rd;
  logic        too_many;

  always_comb begin
    nxt_st   = st_ff;
    nxt_tbuf = tbuf_ff;
    nxt_cnt  = cnt_ff;
    nxt_last = last_ff;
    nxt_isrd = isrd_ff;
    nxt_hv   = 1'b0;
    nxt_hd   = hd_ff;
    nxt_hl   = 1'b0;
    nxt_bta  = 1'b0;
    nxt_rej  = 1'b0;
    nxt_rbuf = rbuf_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rv   = 1'b0;
    nxt_rok  = rok_ff;
    nxt_rd   = rd_ff;
    nxt_re   = re_ff;
    nxt_red  = red_ff;
    is_rd    = (i_cmd_dt == `DT_GEN_RD0) || (i_cmd_dt == `DT_GEN_RD1) ||
               (i_cmd_dt == `DT_GEN_RD2) || (i_cmd_dt == `DT_DCS_RD);
    too_many = (i_cmd_dt[5:4] == 2'b10) && ({2'b00, i_cmd_dt[3:0]} == `DT_DCS_WR0);
    unique case (st_ff)
      spcd_pkg::HOST_IDLE: begin
        if (i_cmd_valid && rdy_ff) begin
          if (too_many) begin
            nxt_rej = 1'b1; // R20
          end else begin
            // Fewer than two parameters: second byte forced to zero
            nxt_tbuf = spcd_pkg::pkt_build({2'b00, i_cmd_dt},
                         {(i_cmd_dt[5:4] == 2'b10) ? i_cmd_d1 : `PARAM_ZERO, // R8 R19
                          i_cmd_d0}); // R18
            nxt_isrd = is_rd; // R9
            nxt_last = is_rd | i_cmd_last; // R16 R11
            nxt_cnt  = 2'(`PKT_BYTES - 1); // R6
            nxt_st   = spcd_pkg::HOST_SEND;
          end
        end
      end
      spcd_pkg::HOST_SEND: begin
        nxt_hv   = 1'b1;
        nxt_hd   = tbuf_ff[7:0];
        nxt_hl   = last_ff && (cnt_ff == 2'b00);
        nxt_tbuf = {8'h00, tbuf_ff[31:8]};
        nxt_cnt  = cnt_ff - 2'b01;
        if (cnt_ff == 2'b00) begin
          nxt_st = isrd_ff ? spcd_pkg::HOST_TURN : spcd_pkg::HOST_IDLE;
        end
      end
      spcd_pkg::HOST_TURN: begin
        nxt_bta  = 1'b1; // R12
        nxt_rcnt = 2'b00;
        nxt_rok  = 1'b0;
        nxt_re   = 1'b0;
        nxt_st   = spcd_pkg::HOST_WAIT;
      end
      spcd_pkg::HOST_WAIT: begin
        if (lnk.d2h_valid) begin
          nxt_rbuf = {lnk.d2h_data, rbuf_ff[23:8]};
          nxt_rcnt = rcnt_ff + 2'b01;
          if (rcnt_ff == 2'b11) begin
            if (rbuf_ff[5:0] == `DT_ERR_RPT) begin
              nxt_re  = 1'b1; // R13
              nxt_red = rbuf_ff[23:8];
            end else begin
              nxt_rok = 1'b1; // R15
              nxt_rd  = rbuf_ff[23:8];
            end
          end
        end
        // Ownership comes back only when the peripheral says so
        if (lnk.d2h_done) begin // R17
          nxt_rv = 1'b1;
          nxt_st = spcd_pkg::HOST_IDLE;
        end
      end
    endcase
    nxt_rdy = (nxt_st == spcd_pkg::HOST_IDLE);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      st_ff   <= spcd_pkg::HOST_IDLE;
      tbuf_ff <= 32'h00000000;
      cnt_ff  <= 2'b00;
      last_ff <= 1'b0;
      isrd_ff <= 1'b0;
      hv_ff   <= 1'b0;
      hd_ff   <= 8'h00;
      hl_ff   <= 1'b0;
      bta_ff  <= 1'b0;
      rdy_ff  <= 1'b0;
      rej_ff  <= 1'b0;
      rbuf_ff <= 24'h000000;
      rcnt_ff <= 2'b00;
      rv_ff   <= 1'b0;
      rok_ff  <= 1'b0;
      rd_ff   <= 16'h0000;
      re_ff   <= 1'b0;
      red_ff  <= 16'h0000;
    end else begin
      st_ff   <= nxt_st;
      tbuf_ff <= nxt_tbuf;
      cnt_ff  <= nxt_cnt;
      last_ff <= nxt_last;
      isrd_ff <= nxt_isrd;
      hv_ff   <= nxt_hv;
      hd_ff   <= nxt_hd;
      hl_ff   <= nxt_hl;
      bta_ff  <= nxt_bta;
      rdy_ff  <= nxt_rdy;
      rej_ff  <= nxt_rej;
      rbuf_ff <= nxt_rbuf;
      rcnt_ff <= nxt_rcnt;
      rv_ff   <= nxt_rv;
      rok_ff  <= nxt_rok;
      rd_ff   <= nxt_rd;
      re_ff   <= nxt_re;
      red_ff  <= nxt_red;
    end
  end

  assign lnk.h2d_valid      = hv_ff;
  assign lnk.h2d_data       = hd_ff;
  assign lnk.h2d_last       = hl_ff;
  assign lnk.bus_turnaround = bta_ff;
  assign o_cmd_ready        = rdy_ff;
  assign o_cmd_reject       = rej_ff;
  assign o_rsp_valid        = rv_ff;
  assign o_rsp_data_ok      = rok_ff;
  assign o_rsp_data         = rd_ff;
  assign o_rsp_err          = re_ff;
  assign o_rsp_err_data     = red_ff;

endmodule : short_packet_command_host

// ===== spcd_link_assertions.sv
`timescale 1ns/10ps
`include "spcd_defs.svh"
module spcd_link_assertions (
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       h2d_valid,
  input  wire logic [7:0] h2d_data,
  input  wire logic       h2d_last,
  input  wire logic       bus_turnaround,
  input  wire logic       d2h_valid,
  input  wire logic [7:0] d2h_data,
  input  wire logic       d2h_done
);
  // Device owns the link from a turnaround until it hands the link back
  logic own_ff;
  logic nxt_own_ff;

  always_comb begin
    nxt_own_ff = own_ff;
    if (bus_turnaround) nxt_own_ff = 1'b1;
    if (d2h_done) nxt_own_ff = 1'b0;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) own_ff <= 1'b0;
    else own_ff <= nxt_own_ff;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_pkt_four_bytes: assert property ($rose(h2d_valid) |-> h2d_valid[*4] ##1 !h2d_valid)
    else $error("host packet is not four bytes");
  a_check_top_zero: assert property ($rose(h2d_valid) |-> ##3 h2d_data[7:6] == 2'b00)
    else $error("check byte top bits set");
  a_second_zero: assert property ($rose(h2d_valid) && h2d_data[5:4] != 2'b10 |-> ##2 h2d_data == 8'h00)
    else $error("unused second data byte not zero");
  a_no_two_param: assert property ($rose(h2d_valid) |-> h2d_data[5:0] != 6'h25)
    else $error("two parameter command sent short");
  a_read_then_turn: assert property ($rose(h2d_valid) && h2d_data[5:0] inside {`DT_GEN_RD0,
    `DT_GEN_RD1, `DT_GEN_RD2, `DT_DCS_RD} |-> ##3 h2d_last ##1 bus_turnaround)
    else $error("read not closed by end and turnaround");
  a_turn_after_end: assert property (bus_turnaround |-> $past(h2d_last))
    else $error("turnaround without transmission end");
  a_resp_bounded: assert property (bus_turnaround |-> ##[2:60] d2h_done)
    else $error("link not returned after turnaround");
  a_dev_sends_owned: assert property (d2h_valid |-> own_ff && !h2d_valid)
    else $error("device sends without owning the link");
  a_resp_whole: assert property ($rose(d2h_valid) |-> d2h_data[7:6] == 2'b00 ##0 d2h_valid[*4])
    else $error("response packet not four bytes");

  c_read_two: cover property ($rose(h2d_valid) && h2d_data[5:0] == `DT_GEN_RD2);
  c_turn_done: cover property (bus_turnaround ##[2:60] d2h_done);
  c_set_write: cover property ($rose(h2d_valid) && h2d_data[5:0] == `DT_DCS_WR1);
endmodule : spcd_link_assertions

// ===== tb.sv
`timescale 1ns/10ps
`include "spcd_defs.svh"
module tb;
  logic        i_mclk, i_rstn, i_cmd_valid, i_cmd_last, i_rd_valid, rd_valid2;
  logic [5:0]  i_cmd_dt;
  logic [7:0]  i_cmd_d0, i_cmd_d1, o_param0, o_param1, p0_2;
  logic        o_cmd_ready, o_cmd_reject, o_rsp_valid, o_rsp_data_ok, o_rsp_err;
  logic        o_low_color, o_display_on, o_gen_wr_valid, o_dcs_wr_valid, o_rd_req, o_rd_dcs;
  logic        e_low, e_on;
  logic [1:0]  o_param_count, o_err_flags, errf2;
  logic [15:0] o_rsp_data, o_rsp_err_data, i_rd_data, rd_data2, rd_val, v;
  logic [15:0] n_gw = '0, n_sw = '0, n_rr = '0, e_gw, e_sw, e_rr;
  logic [7:0]  hb[$], db[$], q2[$];
  int          n_errors, compares;
  logic [5:0]  dts[15] = '{`DT_COLOR_ON, `DT_COLOR_OFF, `DT_SHUTDOWN, `DT_TURN_ON, `DT_GEN_WR0,
    `DT_GEN_WR1, `DT_GEN_WR2, `DT_GEN_RD0, `DT_GEN_RD1, `DT_GEN_RD2, `DT_DCS_WR0, `DT_DCS_WR1,
    `DT_DCS_RD, 6'h25, 6'h0E};

  spcd_if lk ();
  spcd_if lk2 ();
  short_packet_command_host short_packet_command_host_i (.i_mclk, .i_rstn, .lnk(lk.host),
    .i_cmd_valid, .i_cmd_dt, .i_cmd_d0, .i_cmd_d1, .i_cmd_last, .o_cmd_ready, .o_cmd_reject,
    .o_rsp_valid, .o_rsp_data_ok, .o_rsp_data, .o_rsp_err, .o_rsp_err_data);
  short_packet_command_decoder short_packet_command_decoder_i (.i_mclk, .i_rstn,
    .lnk(lk.dev), .o_low_color, .o_display_on, .o_gen_wr_valid, .o_dcs_wr_valid, .o_rd_req,
    .o_rd_dcs, .o_param_count, .o_param0, .o_param1, .o_err_flags, .i_rd_valid, .i_rd_data);
  // Second device fed by hand-made faulty packets
  short_packet_command_decoder short_packet_command_decoder_i2 (.i_mclk, .i_rstn,
    .lnk(lk2.dev), .o_low_color(), .o_display_on(), .o_gen_wr_valid(), .o_dcs_wr_valid(),
    .o_rd_req(), .o_rd_dcs(), .o_param_count(), .o_param0(p0_2), .o_param1(),
    .o_err_flags(errf2), .i_rd_valid(rd_valid2), .i_rd_data(rd_data2));
  spcd_link_assertions spcd_link_assertions_i (.i_mclk, .i_rstn, .h2d_valid(lk.h2d_valid),
    .h2d_data(lk.h2d_data), .h2d_last(lk.h2d_last), .bus_turnaround(lk.bus_turnaround),
    .d2h_valid(lk.d2h_valid), .d2h_data(lk.d2h_data), .d2h_done(lk.d2h_done));

  function automatic logic [7:0] ecc_of(input logic [23:0] h);
    logic [5:0] c;
    int         n;
    ecc_of = 8'h00;
    n = 0;
    for (int k = 3; k < 64 && n < 24; k++) begin
      c = 6'(k);
      if ($countones(c) >= 2) begin
        if (h[n]) ecc_of = ecc_of ^ {2'b00, c};
        n++;
      end
    end
  endfunction : ecc_of

  function automatic logic [31:0] pk(input logic [5:0] dt, input logic [7:0] d0, d1);
    return {ecc_of({d1, d0, 2'b00, dt}), d1, d0, 2'b00, dt};
  endfunction : pk

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic wait_ready();
    for (int i = 0; i < 200 && o_cmd_ready !== 1'b1; i++) @(negedge i_mclk);
  endtask : wait_ready

  task automatic run(input logic [5:0] dt, input logic [7:0] d0, d1);
    logic rd;
    logic rej;
    rd = dt inside {`DT_GEN_RD0, `DT_GEN_RD1, `DT_GEN_RD2, `DT_DCS_RD};
    rej = (dt == 6'h25);
    wait_ready();
    @(posedge i_mclk);
    i_cmd_valid <= 1'b1;
    i_cmd_dt <= dt;
    i_cmd_d0 <= d0;
    i_cmd_d1 <= d1;
    i_cmd_last <= rd | 1'($urandom);
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    @(negedge i_mclk);
    chk(o_cmd_reject, rej);
    case (dt)
      `DT_COLOR_ON: e_low = 1'b1;
      `DT_COLOR_OFF: e_low = 1'b0;
      `DT_SHUTDOWN: e_on = 1'b0;
      `DT_TURN_ON: e_on = 1'b1;
      `DT_GEN_WR0, `DT_GEN_WR1, `DT_GEN_WR2: e_gw++;
      `DT_DCS_WR0, `DT_DCS_WR1: e_sw++;
      default: ;
    endcase
    if (rd) e_rr++;
    wait_ready();
    repeat (2) @(negedge i_mclk);
    chk({o_low_color, o_display_on}, {e_low, e_on});
    chk(n_gw, e_gw);
    chk(n_sw, e_sw);
    chk(n_rr, e_rr);
    chk(o_err_flags, 2'b00);
    if (dt[3:0] inside {4'h3, 4'h4, 4'h5, 4'h6} && !rej) begin
      chk(o_param_count, dt[5:4]);
      chk(o_param0, d0);
      chk(o_param1, dt[5:4] == 2'b10 ? d1 : 8'h00);
    end
    if (rd) begin
      chk({o_rsp_data_ok, o_rsp_err, o_rd_dcs}, {2'b10, dt == `DT_DCS_RD});
      chk(o_rsp_data, rd_val);
      chk(o_rsp_err_data, 16'h0000);
    end
  endtask : run

  task automatic raw(input logic [31:0] p, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge i_mclk);
      lk2.h2d_valid <= 1'b1;
      lk2.h2d_data <= p[8*i +: 8];
      lk2.h2d_last <= (i == nb - 1);
    end
    @(posedge i_mclk);
    lk2.h2d_valid <= 1'b0;
    lk2.h2d_last <= 1'b0;
    repeat (2) @(negedge i_mclk);
  endtask : raw

  task automatic turn2(input logic [31:0] e0, e1, input int nb);
    q2.delete();
    @(posedge i_mclk);
    lk2.bus_turnaround <= 1'b1;
    @(posedge i_mclk);
    lk2.bus_turnaround <= 1'b0;
    for (int i = 0; i < 60 && lk2.d2h_done !== 1'b1; i++) @(negedge i_mclk);
    chk(16'(q2.size()), 16'(nb));
    for (int i = 0; i < nb; i++) chk(q2[i], i < 4 ? e0[8*i +: 8] : e1[8*i-32 +: 8]);
  endtask : turn2

  // Wire monitors: every four-byte packet on lk must carry a matching check byte
  always @(negedge i_mclk) begin
    if (lk.h2d_valid === 1'b1) hb.push_back(lk.h2d_data);
    if (lk.d2h_valid === 1'b1) db.push_back(lk.d2h_data);
    if (lk2.d2h_valid === 1'b1) q2.push_back(lk2.d2h_data);
    if (lk.d2h_done === 1'b1) chk(16'(db.size()), 16'h0000);
    if (hb.size() == 4) begin
      chk(hb[3], ecc_of({hb[2], hb[1], hb[0]}));
      hb.delete();
    end
    if (db.size() == 4) begin
      chk(db[3], ecc_of({db[2], db[1], db[0]}));
      db.delete();
    end
    if (o_gen_wr_valid === 1'b1) n_gw++;
    if (o_dcs_wr_valid === 1'b1) n_sw++;
    if (o_rd_req === 1'b1) n_rr++;
    if (o_rsp_valid === 1'b1) chk(o_cmd_ready, 1'b1);
  end

  // Read data source with a random answer delay
  initial begin
    forever begin
      @(negedge i_mclk);
      if (o_rd_req === 1'b1) begin
        repeat ($urandom_range(0, 5)) @(posedge i_mclk);
        @(posedge i_mclk);
        rd_val = 16'($urandom);
        i_rd_valid <= 1'b1;
        i_rd_data <= rd_val;
        @(posedge i_mclk);
        i_rd_valid <= 1'b0;
      end
    end
  end

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (30000) @(posedge i_mclk);
    n_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(98164));
    {i_rstn, i_cmd_valid, i_cmd_last, i_rd_valid, rd_valid2} = '0;
    {i_cmd_dt, i_cmd_d0, i_cmd_d1, i_rd_data, rd_data2} = '0;
    {lk2.h2d_valid, lk2.h2d_data, lk2.h2d_last, lk2.bus_turnaround} = '0;
    {e_low, e_on, e_gw, e_sw, e_rr} = {2'b01, 48'h0};
    repeat (6) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_mclk);
    foreach (dts[i]) run(dts[i], 8'($urandom), 8'($urandom));
    run(`DT_SHUTDOWN, 8'h00, 8'h00);
    run(`DT_GEN_WR2, 8'hFF, 8'h81);
    run(`DT_TURN_ON, 8'h00, 8'h00);
    run(`DT_GEN_RD2, 8'h00, 8'hFF);
    run(`DT_DCS_RD, 8'hFF, 8'hFF);
    repeat (60) run(dts[$urandom_range(0, 14)], 8'($urandom), 8'($urandom));
    raw(pk(`DT_COLOR_ON, 8'h00, 8'h00), 2);
    chk(errf2, 2'b10);
    raw(pk(`DT_GEN_RD1, 8'h5A, 8'h00) ^ 32'h3000_0000, 4);
    chk(errf2, 2'b10);
    turn2(pk(`DT_ERR_RPT, 8'h00, 8'h02), 32'h0, 4);
    chk(errf2, 2'b00);
    v = 16'($urandom);
    raw(pk(`DT_GEN_RD2, 8'hC3, 8'h3C) ^ 32'h0000_2000, 4);
    chk({errf2, p0_2}, {2'b01, 8'hC3});
    @(posedge i_mclk);
    rd_valid2 <= 1'b1;
    rd_data2 <= v;
    @(posedge i_mclk);
    rd_valid2 <= 1'b0;
    turn2(pk(`DT_RD_RESP, v[7:0], v[15:8]), pk(`DT_ERR_RPT, 8'h00, 8'h01), 8);
    end_sim();
  end
endmodule : tb
